// >>> hdl/lcm_pkg.sv
// constants for the load current monitor readout
// assumes an 8-bit register port and a 9-bit current code from the sense front end
package lcm_pkg;
  localparam int         REG_W      = 8;
  localparam int         CODE_W     = 9;
  localparam int         CODE_HI    = 8;
  localparam logic [7:0] OFS_SELECT = 8'h24;
  localparam logic [7:0] OFS_HIGH   = 8'h25;
  localparam logic [7:0] OFS_LOW    = 8'h26;
  localparam logic [7:0] SELECT_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [8:0] CODE_RST   = 9'h000;
  localparam logic [6:0] HIGH_PAD   = 7'h00;
  localparam logic [7:0] RD_NONE    = 8'h00;
  localparam int         SEL_BIT    = 0;
  localparam logic       TARGET_B0  = 1'b0;
  localparam logic       TARGET_B1  = 1'b1;
  localparam int         LSB_MA     = 20;
  localparam int         FULL_MA    = 10220;
  typedef enum logic [0:0] {
    LCM_IDLE = 1'b0,
    LCM_BUSY = 1'b1
  } lcm_state_t;
endpackage

// >>> hdl/lcm_capture.sv
// result holding register for the load current code
// assumes cap_en is a one-cycle pulse from the sequencer
`timescale 1ns/1ns
module lcm_capture
  import lcm_pkg::*;
(
  input  wire logic              clk_sys,  // system clock
  input  wire logic              sys_rst,  // sync reset, high
  input  wire logic              cap_en,   // take a new code
  input  wire logic [CODE_W-1:0] code_in,  // code from front end
  output logic      [CODE_W-1:0] code_q    // held result
);
  logic [CODE_W-1:0] code_d;

  always_comb
  begin
    code_d = code_q;
    if (cap_en)
    begin
      code_d = code_in;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      code_q <= CODE_RST;
    end
    else
    begin
      code_q <= code_d;
    end
  end

  a_hold_between_caps: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !cap_en |=> code_q == $past(code_q))
    else $error("result changed without a capture");
endmodule

// >>> hdl/lcm_top.sv
// load current monitor readout: select register, measurement start and result registers
// assumes a front end that answers meas_start with one meas_done pulse and a valid code
// assumes register strobes one cycle long, never both at once
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
// Operation
// - select bit 0 picks regulator zero or one
// - each select write starts a new measurement
// - high register shows code bit 8, rest zero
// - low register shows code bits 7 to 0
// - code step is 20 mA, full 10.22 A
module lcm_top
  import lcm_pkg::*;
(
  input  wire logic              clk_sys,    // system clock, 100 MHz
  input  wire logic              sys_rst,    // sync reset, high
  input  wire logic [7:0]        reg_addr,   // register offset
  input  wire logic [REG_W-1:0]  reg_wdata,  // write data
  input  wire logic              reg_wr,     // write strobe
  input  wire logic              reg_rd,     // read strobe
  output logic      [REG_W-1:0]  reg_rdata,  // read data, cycle after strobe
  output logic                   meas_start, // start pulse to front end
  output logic                   meas_target,// regulator being measured
  output logic                   meas_busy,  // measurement in flight
  input  wire logic              meas_done,  // front end result pulse
  input  wire logic [CODE_W-1:0] meas_code   // front end average code
);
  // code range must match the 20 mA step scale
  if (((2 ** CODE_W) - 1) * LSB_MA != FULL_MA)
  begin : g_scale_check
    $error("code width does not match the current scale");
  end

  lcm_state_t        state_q;
  lcm_state_t        state_d;
  logic [REG_W-1:0]  select_q;
  logic [REG_W-1:0]  select_d;
  logic              start_q;
  logic              start_d;
  logic              target_q;
  logic              target_d;
  logic [REG_W-1:0]  rdata_q;
  logic [REG_W-1:0]  rdata_d;
  logic              sel_write;
  logic              capture;
  logic [CODE_W-1:0] code_q;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  assign sel_write = reg_wr && hit(reg_addr, OFS_SELECT);
  // a result arriving while busy is kept even if a rewrite lands in the same cycle
  assign capture = meas_done && (state_q == LCM_BUSY);

  // sequencer and select register
  always_comb
  begin
    state_d  = state_q;
    select_d = select_q;
    start_d  = 1'b0;
    target_d = target_q;
    // any select write restarts, changed value or not
    if (sel_write)
    begin
      select_d = reg_wdata;
      start_d  = 1'b1;
      target_d = reg_wdata[SEL_BIT] ? TARGET_B1 : TARGET_B0;
      state_d  = LCM_BUSY;
    end
    else
    begin
      case (state_q)
        LCM_IDLE:
        begin
          state_d = LCM_IDLE;
        end
        LCM_BUSY:
        begin
          if (meas_done)
          begin
            state_d = LCM_IDLE;
          end
        end
        default:
        begin
          state_d = LCM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q  <= LCM_IDLE;
      select_q <= SELECT_RST;
      start_q  <= 1'b0;
      target_q <= TARGET_B0;
    end
    else
    begin
      state_q  <= state_d;
      select_q <= select_d;
      start_q  <= start_d;
      target_q <= target_d;
    end
  end

  // one capture register for the whole code
  lcm_capture u_capture (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .cap_en  (capture),
    .code_in (meas_code),
    .code_q  (code_q)
  );

  // read decode, unmapped offsets read zero
  always_comb
  begin
    rdata_d = RD_NONE;
    if (reg_rd)
    begin
      if (hit(reg_addr, OFS_SELECT))
      begin
        rdata_d = select_q;
      end
      // bit 8 in bit 0, zero above
      else if (hit(reg_addr, OFS_HIGH))
      begin
        rdata_d = {HIGH_PAD, code_q[CODE_HI]};
      end
      else if (hit(reg_addr, OFS_LOW))
      begin
        rdata_d = code_q[REG_W-1:0];
      end
      else
      begin
        rdata_d = RD_NONE;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rdata_q <= RESULT_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata   = rdata_q;
  assign meas_start  = start_q;
  assign meas_target = target_q;
  assign meas_busy   = (state_q == LCM_BUSY);

  // write gives a start pulse next cycle
  a_write_starts: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_wr && reg_addr == OFS_SELECT |=> meas_start && meas_busy)
    else $error("select write did not start a measurement");

  // no start without a select write
  a_start_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    meas_start |-> $past(reg_wr) && $past(reg_addr) == OFS_SELECT)
    else $error("start pulse without a select write");

  a_target_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    meas_start |-> meas_target == $past(reg_wdata[SEL_BIT]))
    else $error("wrong regulator targeted");

  a_high_layout: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == OFS_HIGH |=> reg_rdata == {HIGH_PAD, $past(code_q[CODE_HI])})
    else $error("high register read wrong");

  a_low_layout: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == OFS_LOW |=> reg_rdata == $past(code_q[REG_W-1:0]))
    else $error("low register read wrong");

  // done while busy lands whole code
  a_capture_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    meas_done && meas_busy |=> code_q == $past(meas_code))
    else $error("completed code not captured");

  // full code never exceeds the scale
  a_scale_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    capture |=> (int'(code_q) * LSB_MA) <= FULL_MA)
    else $error("code beyond current scale");
endmodule

// >>> verif/lcm_fe_model.sv
// sense front end model: one done pulse per start, after lat cycles
// assumes one-cycle start pulses; a new start replaces one in flight
`timescale 1ns/1ns
module lcm_fe_model
  import lcm_pkg::*;
(
  input  wire logic              clk_sys,     // system clock
  input  wire logic              sys_rst,     // sync reset, high
  input  wire logic              meas_start,  // start pulse
  input  wire logic              meas_target, // regulator to measure
  input  wire logic [7:0]        lat,         // answer delay
  input  wire logic [CODE_W-1:0] code_r0,     // code of regulator zero
  input  wire logic [CODE_W-1:0] code_r1,     // code of regulator one
  output logic                   meas_done,   // result pulse
  output logic      [CODE_W-1:0] meas_code    // code, valid with done
);
  logic [7:0] cnt_q;
  logic       tgt_q;
  // code line toggles outside done so a stale value never matches
  always_ff @(posedge clk_sys)
  begin
    meas_done <= 1'b0;
    meas_code <= ~meas_code;
    if (sys_rst)
    begin
      cnt_q <= 8'h00;
      meas_code <= 9'h155;
    end
    else if (meas_start)
    begin
      cnt_q <= lat;
      tgt_q <= meas_target;
    end
    else if (cnt_q == 8'h01)
    begin
      meas_done <= 1'b1;
      meas_code <= tgt_q ? code_r1 : code_r0;
      cnt_q <= 8'h00;
    end
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule

// >>> verif/lcm_top_tb_top.sv
// self-checking bench for the load current readout
// assumes lcm_fe_model in place of the sense front end
`timescale 1ns/1ns
module lcm_top_tb_top;
  import lcm_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic meas_start, meas_target, meas_busy, meas_done;
  logic [8:0] meas_code;
  logic [7:0] lat = 8'h03;
  logic [8:0] code_r0 = 9'h000;
  logic [8:0] code_r1 = 9'h000;
  int bad_count = 0;
  int checked = 0;
  always #5 clk_sys = ~clk_sys;
  lcm_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas_start(meas_start), .meas_target(meas_target), .meas_busy(meas_busy),
    .meas_done(meas_done), .meas_code(meas_code));
  lcm_fe_model fe (.clk_sys(clk_sys), .sys_rst(sys_rst), .meas_start(meas_start),
    .meas_target(meas_target), .lat(lat), .code_r0(code_r0), .code_r1(code_r1),
    .meas_done(meas_done), .meas_code(meas_code));
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, {1'b0, exp}, {1'b0, reg_rdata});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (meas_busy !== 1'b0 && n < 100)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("busy", 9'h000, {8'h00, meas_busy});
  endtask
  task automatic t_reset;
    chk("idle busy", 9'h000, {8'h00, meas_busy});
    chk("idle start", 9'h000, {8'h00, meas_start});
    rd(OFS_SELECT, SELECT_RST, "select");
    rd(OFS_HIGH, 8'h00, "high");
    rd(OFS_LOW, 8'h00, "low");
    rd(8'h30, RD_NONE, "unmapped");
  endtask
  task automatic t_measure(input logic sel, input logic [8:0] c);
    code_r0 <= sel ? ~c : c;
    code_r1 <= sel ? c : ~c;
    wr(OFS_SELECT, {7'h00, sel});
    #1 chk("start", 9'h001, {8'h00, meas_start});
    chk("target", {8'h00, sel}, {8'h00, meas_target});
    wait_idle();
    rd(OFS_HIGH, {7'h00, c[8]}, "high");
    rd(OFS_LOW, c[7:0], "low");
    @(posedge clk_sys);
    #1 chk("rdata idle", 9'h000, {1'b0, reg_rdata});
  endtask
  task automatic t_hold;
    lat <= 8'h28;
    code_r0 <= 9'h0F0;
    code_r1 <= 9'h133;
    wr(OFS_SELECT, 8'h00);
    rd(OFS_LOW, 8'h5A, "held");
    rd(OFS_HIGH, 8'h01, "held high");
    wr(OFS_SELECT, 8'h01);
    #1 chk("restart", 9'h001, {8'h00, meas_start});
    chk("retarget", 9'h001, {8'h00, meas_target});
    wait_idle();
    rd(OFS_HIGH, 8'h01, "high");
    rd(OFS_LOW, 8'h33, "low");
    rd(OFS_SELECT, 8'h01, "select");
    lat <= 8'h03;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_measure(1'b0, 9'h0A5);
    t_measure(1'b1, 9'(FULL_MA / LSB_MA));
    t_measure(1'b1, 9'h15A);
    t_hold();
    give_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
endmodule
